// File: design/pd_cmd_ctrl.sv
// host-side controller: takes wishbone orders, drives memory command pins
// assumes the memory clock is derived from ref_clk_i and changed outside on freq_req_o
//
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module pd_cmd_ctrl #(
    parameter int unsigned RELOCK_CYC = 200,
    parameter int unsigned MAX_PD_CYC = pd_ctrl_pkg::MAX_PD_REFI * pd_ctrl_pkg::REFI_CYC
) (
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        clk_en_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             cs_n_o,
    output logic             ras_n_o,
    output logic             cas_n_o,
    output logic             we_n_o,
    output logic [1:0]       bank_o,
    output logic [12:0]      addr_o,
    output logic             gate_o,
    output logic             term_o,
    output logic             freq_req_o
);
    import pd_ctrl_pkg::*;

    // counters are 24 bits wide; a tiny limit would undercut the gate pulse
    if (RELOCK_CYC < 1 || RELOCK_CYC > 32'h00ff_ffff || MAX_PD_CYC < 16 || MAX_PD_CYC > 32'h00ff_ffff) begin : g_bad_timing
        $error("pd_cmd_ctrl: unusable timing parameters");
    end

    typedef enum logic [2:0] {
        S_RUN    = 3'b000,
        S_PD     = 3'b001,
        S_EXIT   = 3'b011,
        S_RELOCK = 3'b010,
        S_FREQ   = 3'b101
    } state_t;

    state_t      state;
    logic [23:0] cnt;
    logic [7:0]  hold;
    logic [3:0]  banks_open;
    logic [7:0]  xp_cyc;
    logic [7:0]  cke_cyc;
    logic        pending;
    logic [3:0]  p_op;
    logic [1:0]  p_bank;
    logic [12:0] p_addr;
    logic        busy;
    logic        term_on;
    logic        pd_precharge;
    logic        dll_reset_due;
    logic        refused;
    logic        pd_timeout;
    logic        freq_done;

    pin_cmd_if cmd ();

    wire wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr_cmd   = wb_req & wb_we_i & (wb_adr_i == OFS_CMD) & wb_sel_i[0];
    wire wr_tim   = wb_req & wb_we_i & (wb_adr_i == OFS_TIMING);
    wire op_t     op = op_t'(p_op);
    wire burst_go = (op == OP_RD) | (op == OP_WR);
    wire may_issue = pending & ~busy & (hold == 8'h00);
    wire [31:0] status_word = {19'h0, pd_timeout, refused, dll_reset_due, term_on,
                               banks_open, pd_precharge, state, pending};
    wire [31:0] timing_word = {16'h0, cke_cyc, xp_cyc};
    wire [31:0] rd_word = (wb_adr_i == OFS_STATUS) ? status_word :
                          (wb_adr_i == OFS_TIMING) ? timing_word : 32'h0;

    // wishbone: one-cycle answer, unmapped reads zero
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else if (clk_en_i) begin
            wb_ack_o <= wb_req;
            wb_dat_o <= rd_word;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            xp_cyc  <= TIM_XP_RST;
            cke_cyc <= TIM_CKE_RST;
        end else if (clk_en_i && wr_tim) begin
            if (wb_sel_i[0]) xp_cyc <= wb_dat_i[TIM_XP_LSB +: 8];
            if (wb_sel_i[1]) cke_cyc <= wb_dat_i[TIM_CKE_LSB +: 8];
        end
    end

    // next command to the pins
    logic       next_valid;
    logic [3:0] next_code;
    logic       next_gate;
    logic       next_term;
    state_t     next_state;

    always_comb begin
        next_valid = 1'b0;
        next_code  = PIN_NOP;
        next_gate  = cmd.gate;
        next_term  = term_on;
        next_state = state;
        unique case (state)
            S_RUN: begin
                if (may_issue) begin
                    next_valid = 1'b1;
                    unique case (op)
                        OP_ACT:  next_code = PIN_ACT;
                        OP_PRE,
                        OP_PREA: next_code = PIN_PRE;
                        OP_RD:   next_code = PIN_RD;
                        OP_WR:   next_code = PIN_WR;
                        OP_REF:  next_code = PIN_REF;
                        OP_MRS:  next_code = PIN_MRS;
                        OP_PD: begin
                            next_code  = PIN_NOP;
                            next_gate  = 1'b0;
                            next_state = S_PD;
                        end
                        OP_ODT_ON:  next_term = 1'b1;
                        OP_ODT_OFF: next_term = 1'b0;
                        default: next_code = PIN_NOP;
                    endcase
                end
            end
            S_PD: begin
                if ((may_issue && op == OP_PD_EXIT) || cnt >= MAX_PD_CYC[23:0]) begin
                    next_gate  = 1'b1;
                    next_state = S_EXIT;
                end else if (may_issue && op == OP_FREQ && pd_precharge && !term_on
                             && cnt >= FREQ_WAIT_CLK) begin
                    next_state = S_FREQ;
                end
            end
            S_FREQ: begin
                if (may_issue && op == OP_FREQ_OK)
                    next_state = S_PD;
            end
            S_EXIT: begin
                if (hold == 8'h00)
                    next_state = dll_reset_due ? S_RELOCK : S_RUN;
            end
            S_RELOCK: begin
                next_term = 1'b0;
                // dll reset first; waits for software's set command
                if (dll_reset_due && may_issue && op == OP_MRS) begin
                    next_valid = 1'b1;
                    next_code  = PIN_MRS;
                end
                if (cnt >= RELOCK_CYC[23:0] && !dll_reset_due)
                    next_state = S_RUN;
            end
            default: next_state = S_RUN;
        endcase
    end

    // no entry during burst or set
    wire pd_blocked = (op == OP_PD) & (busy | (hold != 8'h00));
    wire consumed = (state == S_RUN && may_issue) ||
                    (state == S_PD && may_issue && (op == OP_PD_EXIT || next_state == S_FREQ)) ||
                    (state == S_FREQ && may_issue && op == OP_FREQ_OK) ||
                    (state == S_RELOCK && next_valid);

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= S_RUN;
            cnt   <= 24'h0;
        end else if (clk_en_i) begin
            state <= next_state;
            // relock time runs from the dll reset, not from the exit
            cnt   <= (next_state != state || (state == S_RELOCK && dll_reset_due)) ? 24'h0 : cnt + 24'h1;
        end
    end

    // hold covers gate pulse and burst length
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hold <= 8'h00;
            busy <= 1'b0;
        end else if (clk_en_i) begin
            if (next_state != state && (next_state == S_PD || next_state == S_EXIT))
                hold <= (next_state == S_EXIT && xp_cyc > cke_cyc) ? xp_cyc : cke_cyc;
            else if (next_valid && (next_code == PIN_RD || next_code == PIN_WR || next_code == PIN_MRS))
                hold <= BURST_CYC[7:0];
            else if (hold != 8'h00)
                hold <= hold - 8'h01;
            busy <= next_valid & burst_go;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pending <= 1'b0;
            p_op    <= 4'h0;
            p_bank  <= 2'h0;
            p_addr  <= 13'h0000;
            refused <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_cmd && !pending) begin
                pending <= 1'b1;
                p_op    <= wb_dat_i[CMD_OP_LSB +: 4];
                p_bank  <= wb_dat_i[CMD_BANK_LSB +: 2];
                p_addr  <= wb_dat_i[CMD_ADDR_LSB +: ADDR_W];
            end else if (consumed && !pd_blocked) begin
                pending <= 1'b0;
            end
            // set wins over clear
            if (wr_cmd && pending)
                refused <= 1'b1;
            else if (wb_req && !wb_we_i && wb_adr_i == OFS_STATUS)
                refused <= 1'b0;
        end
    end

    // bank tracking picks the mode, dll reset due after clock changes
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            banks_open    <= 4'h0;
            pd_precharge  <= 1'b0;
            dll_reset_due <= 1'b0;
            term_on       <= 1'b0;
            pd_timeout    <= 1'b0;
            freq_done     <= 1'b0;
        end else if (clk_en_i) begin
            term_on <= next_term;
            if (next_valid && op == OP_ACT)
                banks_open[p_bank] <= 1'b1;
            else if (next_valid && op == OP_PREA)
                banks_open <= 4'h0;
            else if (next_valid && op == OP_PRE)
                banks_open[p_bank] <= 1'b0;
            else if (next_valid && burst_go && p_addr[AP_BIT])
                banks_open[p_bank] <= 1'b0;
            if (state == S_RUN && next_state == S_PD)
                pd_precharge <= (banks_open == 4'h0);
            if (state == S_FREQ)
                freq_done <= 1'b1;
            else if (state == S_RELOCK)
                freq_done <= 1'b0;
            // dll reset after a clock change
            if (state == S_EXIT && freq_done)
                dll_reset_due <= 1'b1;
            else if (state == S_RELOCK && next_valid)
                dll_reset_due <= 1'b0;
            if (state == S_PD && cnt >= MAX_PD_CYC[23:0])
                pd_timeout <= 1'b1;
            else if (wb_req && !wb_we_i && wb_adr_i == OFS_STATUS)
                pd_timeout <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd.valid  <= 1'b0;
            cmd.code   <= PIN_NOP;
            cmd.bank   <= 2'h0;
            cmd.addr   <= 13'h0000;
            cmd.gate   <= 1'b1;
            cmd.term   <= 1'b0;
            freq_req_o <= 1'b0;
        end else if (clk_en_i) begin
            cmd.valid  <= next_valid & ~pd_blocked;
            cmd.code   <= next_code;
            // bank selects bank or mode register
            cmd.bank   <= p_bank;
            cmd.addr   <= (op == OP_PREA) ? (p_addr | (13'h0001 << AP_BIT)) : p_addr;
            cmd.gate   <= (next_state == S_PD || next_state == S_FREQ) ? 1'b0 : next_gate;
            cmd.term   <= next_term;
            freq_req_o <= (next_state == S_FREQ);
        end
    end

    pd_pin_driver u_drv (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .clk_en_i  (clk_en_i),
        .cmd       (cmd),
        .cs_n_o    (cs_n_o),
        .ras_n_o   (ras_n_o),
        .cas_n_o   (cas_n_o),
        .we_n_o    (we_n_o),
        .bank_o    (bank_o),
        .addr_o    (addr_o),
        .gate_o    (gate_o),
        .term_o    (term_o)
    );
endmodule // pd_cmd_ctrl

// File: design/pd_pin_driver.sv
// registers the memory command pins from the sequencer's request
// assumes one clock; idle cycles become no-operation commands
`timescale 1ns/1ps
module pd_pin_driver (
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        clk_en_i,
    pin_cmd_if.drv           cmd,
    output logic             cs_n_o,
    output logic             ras_n_o,
    output logic             cas_n_o,
    output logic             we_n_o,
    output logic [1:0]       bank_o,
    output logic [12:0]      addr_o,
    output logic             gate_o,
    output logic             term_o
);
    import pd_ctrl_pkg::*;

    wire [3:0] pins = cmd.valid ? cmd.code : PIN_NOP;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= PIN_NOP;
            bank_o <= 2'h0;
            addr_o <= 13'h0000;
            gate_o <= 1'b0;
            term_o <= 1'b0;
        end else if (clk_en_i) begin
            {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= pins;
            bank_o <= cmd.bank;
            addr_o <= cmd.addr;
            gate_o <= cmd.gate;
            term_o <= cmd.term;
        end
    end
endmodule // pd_pin_driver

// File: inc/pd_ctrl_pkg.sv
// constants shared by the power-down command sequencer and its pin driver
// assumes a 10 MHz controller clock; the memory clock is derived outside
package pd_ctrl_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    // wishbone register byte offsets
    localparam logic [3:0] OFS_CMD    = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_TIMING = 4'h8;
    // command register fields
    localparam int unsigned CMD_OP_LSB   = 0;
    localparam int unsigned CMD_BANK_LSB = 4;
    localparam int unsigned CMD_ADDR_LSB = 8;
    localparam int unsigned ADDR_W       = 13;
    localparam int unsigned AP_BIT       = 10;
    // timing register fields (exit latency, gate pulse), in cycles
    localparam int unsigned TIM_XP_LSB   = 0;
    localparam int unsigned TIM_CKE_LSB  = 8;
    localparam logic [7:0]  TIM_XP_RST   = 8'h06;
    localparam logic [7:0]  TIM_CKE_RST  = 8'h03;
    // least wait after gate low before a clock change may start
    localparam int unsigned FREQ_WAIT_CLK = 2;
    // refresh residency limit, in average refresh intervals
    localparam int unsigned MAX_PD_REFI = 9;
    localparam int unsigned REFI_NS     = 7800;
    localparam int unsigned REFI_CYC    = REFI_NS / CLK_PERIOD_NS;
    localparam int unsigned BURST_CYC   = 4 / 2;

    // software command codes
    typedef enum logic [3:0] {
        OP_NOP     = 4'h0,
        OP_ACT     = 4'h1,
        OP_PRE     = 4'h2,
        OP_PREA    = 4'h3,
        OP_RD      = 4'h4,
        OP_WR      = 4'h5,
        OP_REF     = 4'h6,
        OP_MRS     = 4'h7,
        OP_PD      = 4'h8,
        OP_PD_EXIT = 4'h9,
        OP_FREQ    = 4'ha,
        OP_FREQ_OK = 4'hb,
        OP_ODT_ON  = 4'hc,
        OP_ODT_OFF = 4'hd
    } op_t;

    // cs_n, ras_n, cas_n, we_n
    localparam logic [3:0] PIN_DSL = 4'h8;
    localparam logic [3:0] PIN_NOP = 4'h7;
    localparam logic [3:0] PIN_ACT = 4'h3;
    localparam logic [3:0] PIN_PRE = 4'h2;
    localparam logic [3:0] PIN_RD  = 4'h5;
    localparam logic [3:0] PIN_WR  = 4'h4;
    localparam logic [3:0] PIN_REF = 4'h1;
    localparam logic [3:0] PIN_MRS = 4'h0;
endpackage

// File: inc/pin_cmd_if.sv
// one issued memory command travelling from sequencer to pin driver
// both ends run on the same clock
`timescale 1ns/1ps
interface pin_cmd_if;
    logic       valid;
    logic [3:0] code;
    logic [1:0] bank;
    logic [12:0] addr;
    logic       gate;
    logic       term;
    modport seq (output valid, code, bank, addr, gate, term);
    modport drv (input valid, code, bank, addr, gate, term);
endinterface

// File: verification/ddr2_dev_model.sv
// behavioural memory device decoding its command pins
// assumes the pins change just after rising edges of ref_clk_i
`timescale 1ns/1ps
module ddr2_dev_model
    import pd_ctrl_pkg::*;
#(
    parameter bit FAST_EXIT = 1'b1
) (
    input  wire logic        ref_clk_i,
    input  wire logic        cs_n_i,
    input  wire logic        ras_n_i,
    input  wire logic        cas_n_i,
    input  wire logic        we_n_i,
    input  wire logic [1:0]  bank_i,
    input  wire logic [12:0] addr_i,
    input  wire logic        gate_i,
    output logic             seen_o = 1'b0,
    output op_t              op_o,
    output logic [1:0]       bank_o,
    output logic [12:0]      addr_o,
    output logic [3:0]       open_o = 4'h0,
    output logic             pre_pd_o = 1'b0,
    output logic             dll_on_o = 1'b1
);
    logic       gate_q = 1'b0;
    op_t        op_d;
    wire  [3:0] pins = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
    // self-refresh is never entered here, so its asynchronous exit has no path
    // commands count only while the gate stays high
    wire        run  = gate_q && gate_i && !cs_n_i && pins != PIN_NOP;
    // address ten picks the all-bank precharge
    always_comb begin
        case (pins)
            PIN_ACT: op_d = OP_ACT;
            PIN_PRE: op_d = addr_i[AP_BIT] ? OP_PREA : OP_PRE;
            PIN_RD:  op_d = OP_RD;
            PIN_WR:  op_d = OP_WR;
            PIN_REF: op_d = OP_REF;
            default: op_d = OP_MRS;
        endcase
    end
    always @(posedge ref_clk_i) begin
        gate_q <= gate_i;
        seen_o <= run;
        op_o <= op_d;
        bank_o <= bank_i;
        addr_o <= addr_i;
        if (run && op_d == OP_ACT) open_o[bank_i] <= 1'b1;
        if (run && op_d == OP_PRE) open_o[bank_i] <= 1'b0;
        if (run && op_d == OP_PREA) open_o <= 4'h0;
        // kind of power-down and dll by bank state at entry
        if (gate_q && !gate_i) begin
            pre_pd_o <= open_o == 4'h0;
            dll_on_o <= FAST_EXIT && open_o != 4'h0;
        end
        if (!gate_q && gate_i) dll_on_o <= 1'b1;
    end
endmodule // ddr2_dev_model

// File: verification/pd_cmd_ctrl_asserts.sv
// checker on the controller's memory pins and clock-change request
// assumes it is bound to pd_cmd_ctrl and sees only its ports
`timescale 1ns/1ps
module pd_cmd_ctrl_asserts
    import pd_ctrl_pkg::*;
#(
    parameter int unsigned MAX_PD_CYC = 32
) (
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        cs_n_o,
    input  wire logic        ras_n_o,
    input  wire logic        cas_n_o,
    input  wire logic        we_n_o,
    input  wire logic        gate_o,
    input  wire logic        term_o,
    input  wire logic        freq_req_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    wire [3:0]   pins = {cs_n_o, ras_n_o, cas_n_o, we_n_o};
    wire         idle = cs_n_o || pins == PIN_NOP;
    wire         rdwr = pins == PIN_RD || pins == PIN_WR;
    logic [15:0] low_cnt;
    // a forced exit needs a few pipeline cycles beyond the limit itself
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) low_cnt <= '0;
        else low_cnt <= gate_o ? 16'h0 : low_cnt + 16'h1;
    end
    property p_low_hold; $fell(gate_o) |-> !gate_o [*3]; endproperty
    a_low_hold: assert property (p_low_hold) else $error("gate low too short");
    property p_high_hold; $rose(gate_o) |-> gate_o [*3]; endproperty
    a_high_hold: assert property (p_high_hold) else $error("gate high too short");
    property p_entry_nop; $fell(gate_o) |-> idle; endproperty
    a_entry_nop: assert property (p_entry_nop) else $error("entry without nop");
    property p_exit_wait; $rose(gate_o) |-> idle [*6]; endproperty
    a_exit_wait: assert property (p_exit_wait) else $error("command inside exit latency");
    property p_term_held; !gate_o && !$past(gate_o) |-> $stable(term_o); endproperty
    a_term_held: assert property (p_term_held) else $error("termination moved in power-down");
    property p_freq_quiet; freq_req_o |-> !gate_o && !term_o; endproperty
    a_freq_quiet: assert property (p_freq_quiet) else $error("clock change with gate or term");
    property p_freq_wait; $rose(freq_req_o) |-> !$past(gate_o) && !$past(gate_o, 2); endproperty
    a_freq_wait: assert property (p_freq_wait) else $error("clock change too early");
    property p_burst_whole; rdwr |=> idle [*2]; endproperty
    a_burst_whole: assert property (p_burst_whole) else $error("burst interrupted");
    property p_no_drop; rdwr || pins == PIN_MRS |=> gate_o [*2]; endproperty
    a_no_drop: assert property (p_no_drop) else $error("gate low during operation");
    property p_residency; low_cnt <= MAX_PD_CYC + 4; endproperty
    a_residency: assert property (p_residency) else $error("power-down too long");
endmodule // pd_cmd_ctrl_asserts

bind pd_cmd_ctrl pd_cmd_ctrl_asserts #(.MAX_PD_CYC(MAX_PD_CYC)) chk (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .cs_n_o(cs_n_o), .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o), .gate_o(gate_o), .term_o(term_o),
    .freq_req_o(freq_req_o));

// File: verification/test_ddr2_cmd_decode_powerdown.sv
// self-checking bench: wishbone master, device model, expected command queue
// assumes one 10 MHz clock; residency limit shortened by parameter
`timescale 1ns/1ps
module test_ddr2_cmd_decode_powerdown;
    import pd_ctrl_pkg::*;
    localparam int unsigned PD_LIM = 120;
    logic        ref_clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        clk_en_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, cs_n, ras_n, cas_n, we_n, gate, term, freq, seen, pre_pd, dll;
    logic [3:0]  adr = 4'h0, sel = 4'h0, m_open;
    logic [31:0] dat = 32'h0, q, rdat, r, rng = 32'h1afe9e51;
    logic [1:0]  bank, m_bank, b;
    logic [12:0] addr, m_addr, a;
    logic [18:0] e, expq[$];
    op_t         m_op;
    int          fails = 0, compares = 0, open = 0;
    pd_cmd_ctrl #(.RELOCK_CYC(4), .MAX_PD_CYC(PD_LIM)) DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .clk_en_i(clk_en_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_sel_i(sel), .wb_dat_o(q), .wb_ack_o(ack), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n),
        .we_n_o(we_n), .bank_o(bank), .addr_o(addr), .gate_o(gate), .term_o(term), .freq_req_o(freq));
    ddr2_dev_model dev (.ref_clk_i(ref_clk_i), .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n),
        .bank_i(bank), .addr_i(addr), .gate_i(gate), .seen_o(seen), .op_o(m_op), .bank_o(m_bank),
        .addr_o(m_addr), .open_o(m_open), .pre_pd_o(pre_pd), .dll_on_o(dll));
    always #50 ref_clk_i = ~ref_clk_i;
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] x, input string m);
        compares++;
        if (s !== x) begin
            fails++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk_i);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, ad, d, 4'hf};
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rdat = q;
        chk(ack, 1'b1, "no bus answer");
        {cyc, stb, we} <= 3'b000;
    endtask
    task automatic cmd(input op_t o, input logic [1:0] bk, input logic [12:0] ad);
        int n = 0;
        if (o != OP_NOP && o <= OP_MRS) expq.push_back({o, bk, ad});
        if (o == OP_ACT) open = open | (1 << bk);
        if (o == OP_PRE) open = open & ~(1 << bk);
        if (o == OP_PREA) open = 0;
        wb(1'b1, OFS_CMD, {11'h0, ad, 2'h0, bk, o});
        do begin
            wb(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (rdat[0] !== 1'b0 && n < 50);
    endtask
    task automatic wait_lvl(input logic v, input int lim);
        int n = 0;
        while (gate !== v && n < lim) begin
            @(posedge ref_clk_i);
            n++;
        end
    endtask
    task automatic summarize();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        if (seen) begin
            e = expq.size() > 0 ? expq.pop_front() : 19'h7ffff;
            chk(m_op, e[18:15], "command");
            if (m_op != OP_PREA && m_op != OP_REF) chk(m_bank, e[14:13], "bank");
            if (m_op inside {OP_ACT, OP_RD, OP_WR, OP_MRS}) chk(m_addr, e[12:0], "address");
        end
    end
    initial begin
        #2000000;
        fails++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge ref_clk_i);
        chk({gate, term, freq}, 3'b000, "reset pins");
        resetn_i <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        wb(1'b0, OFS_TIMING, 32'h0);
        chk(rdat[15:0], {TIM_CKE_RST, TIM_XP_RST}, "timing reset");
        wb(1'b1, OFS_TIMING, 32'h0407);
        wb(1'b0, OFS_TIMING, 32'h0);
        chk(rdat[15:0], 16'h0407, "timing write");
        wb(1'b0, 4'hc, 32'h0);
        chk(rdat, 32'h0, "unmapped read");
        $display("test registers done");
        for (int i = 0; i < 3; i++) begin
            r = xs();
            b = r[1:0];
            a = r[14:2];
            cmd(OP_ACT, b, a);
            cmd(OP_RD, b, a);
            cmd(OP_WR, b, a ^ 13'h400);
            cmd(OP_PRE, b, a & 13'h1bff);
        end
        cmd(OP_ACT, b, a);
        cmd(OP_PREA, 2'h0, 13'h400);
        cmd(OP_REF, 2'h0, 13'h0);
        for (int k = 0; k < 4; k++) cmd(OP_MRS, 2'(k), a);
        $display("test decode done");
        cmd(OP_ACT, 2'h1, a);
        cmd(OP_PD, 2'h0, 13'h0);
        wait_lvl(1'b0, 40);
        chk({pre_pd, dll}, 2'b01, "active power-down");
        wb(1'b0, OFS_STATUS, 32'h0);
        chk(rdat[8:4], {4'(open), 1'b0}, "status banks");
        cmd(OP_PD_EXIT, 2'h0, 13'h0);
        wait_lvl(1'b1, 40);
        chk(gate, 1'b1, "exit");
        $display("test active power-down done");
        cmd(OP_PREA, 2'h0, 13'h400);
        cmd(OP_PD, 2'h0, 13'h0);
        wait_lvl(1'b0, 40);
        chk({pre_pd, dll, m_open}, 6'h20, "precharge power-down");
        cmd(OP_FREQ, 2'h0, 13'h0);
        chk(freq, 1'b1, "clock change");
        cmd(OP_FREQ_OK, 2'h0, 13'h0);
        cmd(OP_PD_EXIT, 2'h0, 13'h0);
        wait_lvl(1'b1, 40);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk(rdat[10], 1'b1, "dll reset due");
        cmd(OP_MRS, 2'h0, 13'h100);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk(rdat[10], 1'b0, "dll reset done");
        $display("test clock change done");
        cmd(OP_ODT_ON, 2'h0, 13'h0);
        chk(term, 1'b1, "termination on");
        cmd(OP_ODT_OFF, 2'h0, 13'h0);
        chk(term, 1'b0, "termination off");
        cmd(OP_PD, 2'h0, 13'h0);
        wait_lvl(1'b0, 40);
        // a command written in power-down waits there; a second write is refused
        expq.push_back({OP_ACT, 2'h2, a});
        repeat (2) wb(1'b1, OFS_CMD, {11'h0, a, 4'h2, OP_ACT});
        wb(1'b0, OFS_STATUS, 32'h0);
        chk({rdat[11], rdat[0], gate}, 3'b110, "refused in power-down");
        wait_lvl(1'b1, PD_LIM + 40);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk({gate, rdat[12], rdat[11]}, 3'b110, "residency limit");
        repeat (16) @(posedge ref_clk_i);
        $display("test residency done");
        chk(expq.size(), 0, "commands missing");
        summarize();
    end
endmodule // test_ddr2_cmd_decode_powerdown
